//--- pkg/swc_defines.vh
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH

// register byte offsets
`define SWC_OFF_WAIT_SEL     8'h00
`define SWC_OFF_PROC_CLK     8'h04
`define SWC_OFF_STATUS       8'h08

// wait_select_register layout
`define SWC_WAIT_SEL_W       4
`define SWC_WAIT_SEL_RST     4'h0
`define SWC_WAIT_CODE_20     3'h0
`define SWC_WAIT_CODE_17     3'h3
`define SWC_WAIT_CODE_15     3'h5
`define SWC_WAIT_CODE_13     3'h7

// processor_clock_control layout
`define SWC_PCC_RST          4'h0
`define SWC_PCC_STOP_BIT     3
`define SWC_PCC_HALT_BIT     2

// status register layout
`define SWC_ST_KEY_BIT       0
`define SWC_ST_DOG_BIT       1
`define SWC_ST_WAIT_BIT      2
`define SWC_ST_VEC_BIT       3
`define SWC_ST_SRC_LSB       8

// wait lengths in oscillator periods; one period is one clock cycle
`define SWC_CNT_W            21
`define SWC_WAIT_P20         21'h10_0000
`define SWC_WAIT_P17         21'h02_0000
`define SWC_WAIT_P15         21'h00_8000
`define SWC_WAIT_P13         21'h00_2000
`define SWC_WAIT_FIX_IRQ     21'h00_0200
`define SWC_WAIT_FIX_RST     21'h00_0038

// instructions run before a vectored interrupt after wake-up
`define SWC_VEC_DEFER        2'h2

`endif

//--- rtl/swc_fall_detect.v
`default_nettype none

// registered falling-edge detector; inputs are already synchronous
module swc_fall_detect #(
   parameter W = 4
) (
   input  wire         clock,
   input  wire         srst,
   input  wire [W-1:0] level,
   output reg  [W-1:0] fall
);

   reg [W-1:0] prev_q;

   always @(posedge clock) begin
      if (srst) begin
         prev_q <= {W{1'b1}};
         fall   <= {W{1'b0}};
      end else begin
         prev_q <= level;
         fall   <= prev_q & ~level;
      end
   end

endmodule

`default_nettype wire

//--- rtl/swc_wait_counter.v
`default_nettype none

// stabilisation counter; advances only while the oscillator is running
module swc_wait_counter #(
   parameter W = 21
) (
   input  wire         clock,
   input  wire         srst,
   input  wire         start,
   input  wire         run,
   input  wire [W-1:0] limit,
   output reg          done
);

   reg [W-1:0] cnt_q;
   reg [W-1:0] lim_q;
   reg         busy_q;

   always @(posedge clock) begin
      if (srst) begin
         cnt_q  <= {W{1'b0}};
         lim_q  <= {W{1'b0}};
         busy_q <= 1'b0;
         done   <= 1'b0;
      end else if (start) begin
         cnt_q  <= {W{1'b0}};
         lim_q  <= limit;
         busy_q <= 1'b1;
         done   <= 1'b0;
      end else if (busy_q && run) begin
         cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
         if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= lim_q) begin
            busy_q <= 1'b0;
            done   <= 1'b1;
         end
      end else begin
         done <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- rtl/swc_top.v
// The APB register port and the register offsets were decided locally.
`include "swc_defines.vh"
`default_nettype none

module swc_top #(
   parameter N_IRQ          = 4,
   parameter TESTABLE_IDX   = 2,
   parameter N_KEY          = 4,
   parameter VARIABLE_WAIT  = 1,
   parameter RESET_WAIT_LONG = 1,
   parameter [20:0] WAIT_20 = `SWC_WAIT_P20,
   parameter [20:0] WAIT_17 = `SWC_WAIT_P17,
   parameter [20:0] WAIT_15 = `SWC_WAIT_P15,
   parameter [20:0] WAIT_13 = `SWC_WAIT_P13
) (
   input  wire             clock,
   input  wire             srst,
   input  wire [7:0]       paddr,
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [31:0]      pwdata,
   output reg  [31:0]      prdata,
   output reg              pready,
   output reg              pslverr,
   input  wire             stop_exec,
   input  wire             halt_exec,
   input  wire             instr_retired,
   input  wire [N_IRQ-1:0] irq_flags,
   input  wire [N_IRQ-1:0] interrupt_enable_flag,
   input  wire             global_interrupt_enable,
   input  wire             reset_pin_n,
   input  wire [N_KEY-1:0] key_return_input,
   input  wire             key_reset_enable_pin,
   input  wire             dog_overflow_set,
   input  wire             osc_ready,
   output reg              osc_run,
   output reg              cpu_clk_en,
   output reg              core_reset,
   output reg              vector_take,
   output reg              resume_inline,
   output reg  [N_IRQ-1:0] wake_source,
   output reg              key_wake_flag,
   output reg              dog_overflow_flag
);

   localparam [7:0] S_RUN    = 8'h01;
   localparam [7:0] S_HALT   = 8'h02;
   localparam [7:0] S_STOP   = 8'h04;
   localparam [7:0] S_RST    = 8'h08;
   localparam [7:0] S_OSCUP  = 8'h10;
   localparam [7:0] S_WAIT   = 8'h20;
   localparam [7:0] S_RESUME = 8'h40;
   localparam [7:0] S_DEFER  = 8'h80;

   localparam CW = `SWC_CNT_W;

   reg  [7:0]                  state_q;
   reg  [`SWC_WAIT_SEL_W-1:0]  wait_sel_q;
   reg  [3:0]                  pcc_q;
   reg                         rst_kind_q;
   reg  [1:0]                  defer_q;
   reg                         cnt_start_q;
   reg  [CW-1:0]               cnt_limit_q;
   wire                        cnt_done;
   wire [N_KEY-1:0]            key_fall;
   wire [N_IRQ-1:0]            pending;
   reg  [N_IRQ-1:0]            first_pend;
   reg  [CW-1:0]               irq_wait;
   wire [CW-1:0]               rst_wait;
   wire                        key_reset;
   wire                        wr_en;
   wire                        rd_en;
   wire                        mapped;
   wire                        sw_clr_key;
   wire                        sw_clr_dog;
   integer                     i;

   // only sources whose enable is set can count as a wake-up
   assign pending   = irq_flags & interrupt_enable_flag;
   assign key_reset = (state_q == S_STOP) && key_reset_enable_pin && (|key_fall);

   // lowest index wins when several enabled requests arrive together
   always @* begin
      first_pend = {N_IRQ{1'b0}};
      for (i = N_IRQ - 1; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            first_pend = {N_IRQ{1'b0}};
            first_pend[i] = 1'b1;
         end
      end
   end

   // interrupt-wake wait: variable select code or fixed length
   always @* begin
      if (VARIABLE_WAIT != 0) begin
         case (wait_sel_q[2:0])
            `SWC_WAIT_CODE_17: irq_wait = WAIT_17;
            `SWC_WAIT_CODE_15: irq_wait = WAIT_15;
            `SWC_WAIT_CODE_13: irq_wait = WAIT_13;
            // prohibited codes fall back to the longest, safest wait
            default:           irq_wait = WAIT_20;
         endcase
      end else begin
         irq_wait = `SWC_WAIT_FIX_IRQ;
      end
   end

   // reset-release wait is a build-time choice, not software selectable
   assign rst_wait = (VARIABLE_WAIT == 0) ? `SWC_WAIT_FIX_RST :
                     (RESET_WAIT_LONG != 0) ? WAIT_17 : WAIT_15;

   swc_fall_detect #(
      .W (N_KEY)
   ) u_key_fall (
      .clock (clock),
      .srst  (srst),
      .level (key_return_input),
      .fall  (key_fall)
   );

   // counter advances only once the oscillator reports it is running
   swc_wait_counter #(
      .W (CW)
   ) u_wait (
      .clock (clock),
      .srst  (srst),
      .start (cnt_start_q),
      .run   (osc_ready & osc_run),
      .limit (cnt_limit_q),
      .done  (cnt_done)
   );

   // sequencer
   always @(posedge clock) begin
      if (srst) begin
         state_q       <= S_RUN;
         osc_run       <= 1'b1;
         cpu_clk_en    <= 1'b1;
         core_reset    <= 1'b0;
         vector_take   <= 1'b0;
         resume_inline <= 1'b0;
         wake_source   <= {N_IRQ{1'b0}};
         rst_kind_q    <= 1'b0;
         defer_q       <= 2'h0;
         cnt_start_q   <= 1'b0;
         cnt_limit_q   <= {CW{1'b0}};
      end else begin
         vector_take   <= 1'b0;
         resume_inline <= 1'b0;
         cnt_start_q   <= 1'b0;
         if (!reset_pin_n) begin
            // reset pin overrides every state and holds the core in reset
            state_q    <= S_RST;
            core_reset <= 1'b1;
            cpu_clk_en <= 1'b0;
            osc_run    <= 1'b1;
         end else begin
            case (state_q)
               S_RUN: begin
                  if (stop_exec) begin
                     state_q    <= S_STOP;
                     osc_run    <= 1'b0;
                     cpu_clk_en <= 1'b0;
                  end else if (halt_exec) begin
                     state_q    <= S_HALT;
                     cpu_clk_en <= 1'b0;
                  end
               end
               S_HALT: begin
                  if (|pending) begin
                     wake_source <= first_pend;
                     cpu_clk_en  <= 1'b1;
                     state_q     <= S_RESUME;
                  end
               end
               S_STOP: begin
                  if (key_reset) begin
                     // key reset is a pulse, so no pin hold: go straight to the wait
                     core_reset  <= 1'b1;
                     rst_kind_q  <= 1'b1;
                     osc_run     <= 1'b1;
                     cnt_limit_q <= rst_wait;
                     state_q     <= S_OSCUP;
                  end else if (|pending) begin
                     wake_source <= first_pend;
                     rst_kind_q  <= 1'b0;
                     osc_run     <= 1'b1;
                     cnt_limit_q <= irq_wait;
                     state_q     <= S_OSCUP;
                  end
               end
               S_RST: begin
                  rst_kind_q  <= 1'b1;
                  cnt_limit_q <= rst_wait;
                  state_q     <= S_OSCUP;
               end
               S_OSCUP: begin
                  cnt_start_q <= 1'b1;
                  state_q     <= S_WAIT;
               end
               S_WAIT: begin
                  if (cnt_done) begin
                     cpu_clk_en <= 1'b1;
                     if (rst_kind_q) begin
                        core_reset <= 1'b0;
                        state_q    <= S_RUN;
                     end else begin
                        state_q <= S_RESUME;
                     end
                  end
               end
               S_RESUME: begin
                  if (global_interrupt_enable && !wake_source[TESTABLE_IDX]) begin
                     defer_q <= 2'h0;
                     state_q <= S_DEFER;
                  end else begin
                     // request flag is left untouched for the inline path
                     resume_inline <= 1'b1;
                     state_q       <= S_RUN;
                  end
               end
               S_DEFER: begin
                  if (defer_q == `SWC_VEC_DEFER) begin
                     vector_take <= 1'b1;
                     state_q     <= S_RUN;
                  end else if (instr_retired) begin
                     defer_q <= defer_q + 2'h1;
                  end
               end
               default: begin
                  state_q    <= S_RUN;
                  osc_run    <= 1'b1;
                  cpu_clk_en <= 1'b1;
                  core_reset <= 1'b0;
               end
            endcase
         end
      end
   end

   // apb slave: one wait cycle, registered answer; writes land on the completing edge
   assign wr_en  = psel && penable && pready && pwrite;
   assign rd_en  = psel && penable && !pready && !pwrite;
   assign mapped = (paddr == `SWC_OFF_WAIT_SEL) || (paddr == `SWC_OFF_PROC_CLK) ||
                   (paddr == `SWC_OFF_STATUS);
   assign sw_clr_key = wr_en && (paddr == `SWC_OFF_STATUS) && pwdata[`SWC_ST_KEY_BIT];
   assign sw_clr_dog = wr_en && (paddr == `SWC_OFF_STATUS) && pwdata[`SWC_ST_DOG_BIT];

   always @(posedge clock) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata  <= 32'h0000_0000;
         if (rd_en) begin
            case (paddr)
               `SWC_OFF_WAIT_SEL: prdata[`SWC_WAIT_SEL_W-1:0] <= wait_sel_q;
               `SWC_OFF_PROC_CLK: prdata[3:0] <= pcc_q;
               `SWC_OFF_STATUS: begin
                  prdata[`SWC_ST_KEY_BIT] <= key_wake_flag;
                  prdata[`SWC_ST_DOG_BIT] <= dog_overflow_flag;
                  prdata[`SWC_ST_WAIT_BIT] <= (state_q == S_WAIT) || (state_q == S_OSCUP);
                  prdata[`SWC_ST_VEC_BIT] <= (state_q == S_DEFER);
                  prdata[`SWC_ST_SRC_LSB +: N_IRQ] <= wake_source;
               end
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software-visible registers
   always @(posedge clock) begin
      if (srst) begin
         wait_sel_q <= `SWC_WAIT_SEL_RST;
         pcc_q      <= `SWC_PCC_RST;
      end else begin
         if (wr_en && (paddr == `SWC_OFF_WAIT_SEL)) begin
            wait_sel_q <= pwdata[`SWC_WAIT_SEL_W-1:0];
         end
         if (wr_en && (paddr == `SWC_OFF_PROC_CLK)) begin
            pcc_q[1:0] <= pwdata[1:0];
         end
         if (!reset_pin_n) begin
            pcc_q <= `SWC_PCC_RST;
         end else if (state_q == S_RUN && stop_exec) begin
            pcc_q[`SWC_PCC_STOP_BIT] <= 1'b1;
         end else if (state_q == S_RUN && halt_exec) begin
            pcc_q[`SWC_PCC_HALT_BIT] <= 1'b1;
         end else if (state_q == S_RESUME || (state_q == S_WAIT && cnt_done && rst_kind_q)) begin
            pcc_q[`SWC_PCC_STOP_BIT] <= 1'b0;
            pcc_q[`SWC_PCC_HALT_BIT] <= 1'b0;
         end
      end
   end

   // wake cause flags: hardware set beats any clear in the same cycle
   always @(posedge clock) begin
      if (srst) begin
         key_wake_flag     <= 1'b0;
         dog_overflow_flag <= 1'b0;
      end else begin
         if (key_reset) begin
            key_wake_flag <= 1'b1;
         end else if (!reset_pin_n || sw_clr_key) begin
            key_wake_flag <= 1'b0;
         end
         // a key reset leaves the watchdog flag as it was
         if (dog_overflow_set) begin
            dog_overflow_flag <= 1'b1;
         end else if (!reset_pin_n || sw_clr_dog) begin
            dog_overflow_flag <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

//--- verification/swc_top_chk.sv
`default_nettype none
module swc_top_chk #(
   parameter N_IRQ = 4
) (
   input wire logic             clock,
   input wire logic             srst,
   input wire logic             stop_exec,
   input wire logic             halt_exec,
   input wire logic             instr_retired,
   input wire logic [N_IRQ-1:0] irq_flags,
   input wire logic [N_IRQ-1:0] interrupt_enable_flag,
   input wire logic             reset_pin_n,
   input wire logic             key_reset_enable_pin,
   input wire logic             dog_overflow_set,
   input wire logic             osc_run,
   input wire logic             cpu_clk_en,
   input wire logic             core_reset,
   input wire logic             vector_take,
   input wire logic             resume_inline,
   input wire logic             key_wake_flag,
   input wire logic             dog_overflow_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic run_ok = cpu_clk_en && !core_reset && reset_pin_n;
   wire logic pend = |(irq_flags & interrupt_enable_flag);
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   a_stop_halts_osc: assert property (stop_exec && run_ok |=> !osc_run && !cpu_clk_en)
      else $error("stop left clocks running");
   a_halt_keeps_osc: assert property (halt_exec && !stop_exec && run_ok |=> osc_run && !cpu_clk_en)
      else $error("halt gating wrong");
   a_no_idle_wake: assert property (!osc_run && !pend && reset_pin_n && !key_reset_enable_pin |=> !osc_run)
      else $error("stop left without enabled request");
   a_irq_wakes_stop: assert property (!osc_run && pend && reset_pin_n |=> osc_run && !cpu_clk_en)
      else $error("enabled request did not restart oscillator");
   a_pin_clears: assert property (!reset_pin_n && !dog_overflow_set |=> core_reset && !cpu_clk_en && osc_run
      && !key_wake_flag && !dog_overflow_flag)
      else $error("reset pin effect wrong");
   a_wait_before_cpu: assert property ($rose(osc_run) |-> !cpu_clk_en [*8])
      else $error("cpu clock released before wait");
   a_cpu_needs_osc: assert property (cpu_clk_en |-> osc_run)
      else $error("cpu clock without oscillator");
   a_reset_blocks_cpu: assert property (core_reset |-> !cpu_clk_en)
      else $error("cpu clock during reset");
   a_vector_after_instr: assert property (vector_take |-> $past(instr_retired, 2))
      else $error("vector not after instruction");
   a_pulse_single: assert property (vector_take || resume_inline |=> !vector_take && !resume_inline)
      else $error("resume pulse too long");
endmodule
bind swc_top swc_top_chk #(.N_IRQ(N_IRQ)) u_chk (.clock, .srst, .stop_exec, .halt_exec, .instr_retired,
   .irq_flags, .interrupt_enable_flag, .reset_pin_n, .key_reset_enable_pin, .dog_overflow_set, .osc_run,
   .cpu_clk_en, .core_reset, .vector_take, .resume_inline, .key_wake_flag, .dog_overflow_flag);
`default_nettype wire

//--- verification/swc_src_model.sv
`default_nettype none
module swc_src_model #(
   parameter N_IRQ = 4,
   parameter N_KEY = 4,
   parameter OSC_START = 5
) (
   input  wire logic             clock,
   input  wire logic             osc_run,
   output logic      [N_IRQ-1:0] irq_flags,
   output logic      [N_IRQ-1:0] interrupt_enable_flag,
   output logic                  reset_pin_n,
   output logic      [N_KEY-1:0] key_return_input,
   output logic                  osc_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] up_q = 4'h0;
   initial begin
      irq_flags = '0;
      interrupt_enable_flag = '0;
      reset_pin_n = 1'b1;
      key_return_input = '1;
      osc_ready = 1'b0;
   end
   // start-up delay is not counted by the wait, so ready lags the restart
   always @(posedge clock) begin
      if (osc_run !== 1'b1) begin
         up_q <= 4'h0;
         osc_ready <= 1'b0;
      end else if (up_q < OSC_START) begin
         up_q <= up_q + 4'h1;
      end else begin
         osc_ready <= 1'b1;
      end
   end
   task automatic arm(input int i);
      @(posedge clock);
      irq_flags <= '0;
      interrupt_enable_flag <= '0;
      @(posedge clock);
      interrupt_enable_flag[i] <= 1'b1;
      @(posedge clock);
      irq_flags[i] <= 1'b0;
   endtask
   task automatic raise(input int i);
      @(posedge clock);
      irq_flags[i] <= 1'b1;
   endtask
   task automatic quiet();
      @(posedge clock);
      irq_flags <= '0;
      interrupt_enable_flag <= '0;
   endtask
   task automatic key_set(input int k, input logic v);
      @(posedge clock);
      key_return_input[k] <= v;
   endtask
   task automatic pin_low(input int n);
      @(posedge clock);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge clock);
      reset_pin_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RW = 32;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        stop_exec = 1'b0, halt_exec = 1'b0, instr_retired = 1'b0;
   logic        global_interrupt_enable = 1'b0, dog_overflow_set = 1'b0;
   logic        key_reset_enable_pin = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, osc_run, cpu_clk_en, core_reset, vector_take, resume_inline;
   logic        key_wake_flag, dog_overflow_flag, reset_pin_n, osc_ready;
   logic [3:0]  irq_flags, interrupt_enable_flag, key_return_input, wake_source;
   logic [7:0]  seed = 8'h26;
   int          n_fail = 0, check_count = 0, n_inl = 0, n_vec = 0;
   always #2 clock = ~clock;
   swc_top #(.WAIT_20(21'h00_0040), .WAIT_17(21'h00_0020), .WAIT_15(21'h00_0010), .WAIT_13(21'h00_0008)) dut (
      .clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .stop_exec,
      .halt_exec, .instr_retired, .irq_flags, .interrupt_enable_flag, .global_interrupt_enable, .reset_pin_n,
      .key_return_input, .key_reset_enable_pin, .dog_overflow_set, .osc_ready, .osc_run, .cpu_clk_en,
      .core_reset, .vector_take, .resume_inline, .wake_source, .key_wake_flag, .dog_overflow_flag);
   swc_src_model m (.clock, .osc_run, .irq_flags, .interrupt_enable_flag, .reset_pin_n, .key_return_input,
      .osc_ready);
   always @(posedge clock) begin
      if (resume_inline === 1'b1) n_inl++;
      if (vector_take === 1'b1) n_vec++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic int wlim(input logic [2:0] c);
      case (c)
         3'h3: return 32;
         3'h5: return 16;
         3'h7: return 8;
         default: return 64;
      endcase
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int k = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(k < 16, 1'b1);
   endtask
   task automatic pulse(input int s);
      @(posedge clock);
      seed = lfsr(seed);
      stop_exec <= (s == 0);
      halt_exec <= (s == 1);
      // stray retire pulses land only outside a deferred vector and must be ignored
      instr_retired <= (s == 2) || seed[0];
      dog_overflow_set <= (s == 3);
      @(posedge clock);
      stop_exec <= 1'b0;
      halt_exec <= 1'b0;
      instr_retired <= 1'b0;
      dog_overflow_set <= 1'b0;
   endtask
   // bounded wait: 0 cpu clock on, 1 core reset off, 2 oscillator ready
   task automatic wt(input int s, output int n);
      n = 0;
      while ((s == 0 ? cpu_clk_en : s == 1 ? !core_reset : osc_ready) !== 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      chk(n < 400, 1'b1);
   endtask
   initial begin
      logic [31:0] r;
      logic        e;
      logic [2:0]  c;
      logic [1:0]  pw;
      int          n, k, i0;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      for (i0 = 0; i0 < 4; i0++) begin
         apb(1'b0, 8'(i0 * 4), 32'h0, r, e);
         chk(r, 32'h0);
         chk(e, i0 == 3);
      end
      seed = lfsr(seed);
      pw = seed[1:0];
      apb(1'b1, 8'h04, {30'h0, pw}, r, e);
      repeat (4) @(posedge clock);
      m.arm(1);
      pulse(1);
      repeat (2) @(posedge clock);
      chk({osc_run, cpu_clk_en}, 2'b10);
      apb(1'b0, 8'h04, 32'h0, r, e);
      chk(r, {28'h0, 4'h4 | pw});
      n = n_inl;
      m.raise(1);
      wt(0, k);
      repeat (3) @(posedge clock);
      chk(n_inl, n + 1);
      chk(wake_source, 4'h2);
      apb(1'b0, 8'h04, 32'h0, r, e);
      chk(r, {30'h0, pw});
      seed = lfsr(seed);
      for (i0 = 0; i0 < 5; i0++) begin
         c = (i0 == 4) ? seed[2:0] : (i0 == 0) ? 3'h0 : 3'(2 * i0 + 1);
         apb(1'b1, 8'h00, {29'h0, c}, r, e);
         m.arm(0);
         pulse(0);
         m.raise(3);
         repeat (4) @(posedge clock);
         chk({osc_run, cpu_clk_en}, 2'b00);
         apb(1'b0, 8'h04, 32'h0, r, e);
         chk(r[3:0], 4'h8 | pw);
         n = n_inl;
         m.raise(0);
         wt(2, k);
         wt(0, k);
         chk(k >= wlim(c) && k <= wlim(c) + 3, 1'b1);
         repeat (3) @(posedge clock);
         chk(n_inl, n + 1);
         chk(wake_source, 4'h1);
      end
      global_interrupt_enable <= 1'b1;
      for (i0 = 0; i0 < 3; i0 += 2) begin
         m.arm(i0);
         pulse(1);
         n = n_inl;
         k = n_vec;
         m.raise(i0);
         repeat (8) @(posedge clock);
         pulse(2);
         repeat (3) @(posedge clock);
         chk(n_vec, k);
         pulse(2);
         repeat (3) @(posedge clock);
         chk(n_vec, k + (i0 != 2));
         chk(n_inl, n + (i0 == 2));
      end
      global_interrupt_enable <= 1'b0;
      pulse(3);
      m.quiet();
      key_reset_enable_pin <= 1'b1;
      pulse(0);
      repeat (4) @(posedge clock);
      m.key_set(2, 1'b0);
      wt(2, k);
      wt(1, k);
      chk(k >= RW && k <= RW + 6, 1'b1);
      chk({key_wake_flag, dog_overflow_flag}, 2'b11);
      apb(1'b0, 8'h08, 32'h0, r, e);
      chk(r, 32'h0000_0403);
      apb(1'b1, 8'h08, 32'h0000_0001, r, e);
      apb(1'b0, 8'h08, 32'h0, r, e);
      chk(r, 32'h0000_0402);
      m.key_set(2, 1'b1);
      key_reset_enable_pin <= 1'b0;
      pulse(1);
      m.pin_low(3);
      chk(core_reset, 1'b1);
      wt(1, k);
      chk(k >= RW && k <= RW + 6, 1'b1);
      chk({key_wake_flag, dog_overflow_flag}, 2'b00);
      wrap_up();
   end
   initial begin
      #40_000;
      n_fail++;
      wrap_up();
   end
endmodule
`default_nettype wire
